// >>> include/pm6_pkg.sv
/*
  Shared constants, types and decoding for the port-six pin block.
  Assumes a 32-bit AXI4-Lite register bus and an 18-bit byte address.
*/
package pm6_pkg;

  localparam int AW = 18;
  localparam int DW = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_DIR = 16'hFFB9;
  localparam logic [15:0] IDX_LAT = 16'hFFBB;
  localparam logic [15:0] IDX_CTL = 16'hFFC0;
  localparam logic [15:0] IDX_SEL = 16'hFFC1;

  // Reset values and the fixed answer of the write-only register.
  localparam logic [7:0]  DIR_RST    = 8'h00;
  localparam logic [7:0]  LAT_RST    = 8'h00;
  localparam logic [7:0]  CTL_RST    = 8'h00;
  localparam logic [11:0] SEL_RST    = 12'h000;
  localparam logic [7:0]  DIR_RD_VAL = 8'hFF;

  // Field positions in the control and select registers.
  localparam int CTL_HOE     = 0;
  localparam int CTL_CLAMP_OUT_ENABLE    = 1;
  localparam int CTL_OEB     = 2;
  localparam int CTL_CCLR_LO = 3;
  localparam int CTL_CCLR_HI = 4;
  localparam int CTL_CKS_LSB = 5;
  localparam int CKS_W       = 3;
  localparam int SEL_OSX_LSB = 0;
  localparam int SEL_OS1_LSB = 4;
  localparam int SEL_OS0_LSB = 8;
  localparam int OS_W        = 4;
  localparam int SEL_W       = 12;

  // Clock-source codes at or above this value pick the external clock.
  localparam logic [2:0] CKS_EXT_MIN = 3'h5;

  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [23:0] PAD24   = 24'h000000;
  localparam logic [19:0] PAD20   = 20'h00000;

  // Channel state of the bus slave, one-hot.
  typedef enum logic [1:0] {
    CH_IDLE = 2'b01,
    CH_RESP = 2'b10
  } pm6_chan_t;

  // Output levels offered by the timers and the sync logic.
  typedef struct packed {
    logic hsync;
    logic aux_x;
    logic timer_unit_one;
    logic timer_unit_zero;
    logic frt_b;
    logic clamp;
  } pm6_per_out_t;

  // Pin levels handed on to the timers and the expansion converter.
  typedef struct packed {
    logic [3:0] exp_conv;
    logic       csync;
    logic       t1_rst;
    logic       t1_clk;
    logic       frt_d;
    logic       hsync_in;
    logic       frt_c;
  } pm6_feed_t;

  // Function-select controls as the mux sees them.
  typedef struct packed {
    logic       hsync_out_enable;
    logic       clamp_out_enable;
    logic       frt_out_b_enable;
    logic       cclr_hi;
    logic       cclr_lo;
    logic [2:0] cks;
    logic [3:0] osx;
    logic [3:0] os1;
    logic [3:0] os0;
  } pm6_ctrl_t;

  // One-hot register hit: bit0 direction, 1 latch, 2 control, 3 select.
  function automatic logic [3:0] reg_hit(input logic [AW-1:0] a);
    reg_hit = {a[AW-1:2] == IDX_SEL, a[AW-1:2] == IDX_CTL,
               a[AW-1:2] == IDX_LAT, a[AW-1:2] == IDX_DIR};
  endfunction

endpackage

// >>> hw/pm6_axil_slave.sv
/*
  AXI4-Lite slave front end for the port-six registers.
  Assumes the parent supplies read data for the presented read address.
*/
`timescale 1ns/1ps
module pm6_axil_slave
  import pm6_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [pm6_pkg::AW-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [pm6_pkg::DW-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [pm6_pkg::AW-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [pm6_pkg::DW-1:0] rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   wr_en,
  output logic [pm6_pkg::AW-1:0] wr_addr,
  output logic [pm6_pkg::DW-1:0] wr_data,
  output logic [3:0]             wr_strb,
  output logic [pm6_pkg::AW-1:0] rd_addr,
  input  wire logic [pm6_pkg::DW-1:0] rd_data
);
  pm6_chan_t wst_r;
  pm6_chan_t rst_r;

  // A write fires once address and data are both held.
  assign wr_en   = (wst_r == CH_IDLE) && !awready && !wready;
  assign rd_addr = araddr;

  // Write channels are taken in either order, then answered.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wst_r   <= CH_IDLE;
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= RESP_OK;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        wr_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wr_data <= wdata;
        wr_strb <= wstrb;
        wready  <= 1'b0;
      end
      case (wst_r)
        CH_IDLE:
        begin
          if (wr_en)
          begin
            wst_r  <= CH_RESP;
            bvalid <= 1'b1;
            bresp  <= (|reg_hit(wr_addr)) ? RESP_OK : RESP_ERR;
          end
        end
        CH_RESP:
        begin
          if (bready)
          begin
            wst_r   <= CH_IDLE;
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
          end
        end
        default: wst_r <= CH_IDLE;
      endcase
    end
  end

  // Read data is captured when the address is taken.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rst_r   <= CH_IDLE;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OK;
    end
    else
    begin
      case (rst_r)
        CH_IDLE:
        begin
          if (arvalid)
          begin
            rst_r   <= CH_RESP;
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_data;
            rresp   <= (|reg_hit(araddr)) ? RESP_OK : RESP_ERR;
          end
        end
        CH_RESP:
        begin
          if (rready)
          begin
            rst_r   <= CH_IDLE;
            rvalid  <= 1'b0;
            arready <= 1'b1;
          end
        end
        default: rst_r <= CH_IDLE;
      endcase
    end
  end
endmodule

// >>> hw/pm6_pin_mux.sv
/*
  Combinational function selection for the eight port-six pins.
  Assumes the parent registers every result before it leaves the block.
*/
`timescale 1ns/1ps
module pm6_pin_mux
  import pm6_pkg::*;
(
  input  wire logic [7:0]            dir,
  input  wire logic [7:0]            lat,
  input  wire logic [7:0]            pins,
  input  wire pm6_pkg::pm6_ctrl_t    ctl,
  input  wire pm6_pkg::pm6_per_out_t per,
  output logic [7:0]                 pin_o,
  output logic [7:0]                 pin_oe,
  output pm6_pkg::pm6_feed_t         feed
);
  // A compare output is claimed by any nonzero select code.
  function automatic logic sel_on(input logic [3:0] os);
    sel_on = |os;
  endfunction

  wire x_on  = sel_on(ctl.osx);
  wire t1_on = sel_on(ctl.os1);
  wire t0_on = sel_on(ctl.os0);

  // Lower four pins and bit five are plain ports by direction bit.
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_plain
      if (g < 4 || g == 5)
      begin : g_io
        assign pin_o[g]  = lat[g];
        assign pin_oe[g] = dir[g];
      end
    end
  endgenerate

  // Bit four: clamp, then timer 0, then the port.
  assign pin_o[4]  = ctl.clamp_out_enable ? per.clamp : t0_on ? per.timer_unit_zero : lat[4];
  assign pin_oe[4] = (ctl.clamp_out_enable || t0_on) ? 1'b1 : dir[4];

  // Bit six: free-running timer output B, else the port.
  assign pin_o[6]  = ctl.frt_out_b_enable ? per.frt_b : lat[6];
  assign pin_oe[6] = ctl.frt_out_b_enable ? 1'b1 : dir[6];

  // Bit seven: sync, then aux timer X, then timer 1, then the port.
  assign pin_o[7]  = ctl.hsync_out_enable ? per.hsync : x_on ? per.aux_x :
                     t1_on ? per.timer_unit_one : lat[7];
  assign pin_oe[7] = (ctl.hsync_out_enable || x_on || t1_on) ? 1'b1 : dir[7];

  // Input feeds are always live; two are gated by timer 1 settings.
  assign feed.exp_conv = pins[7:4];
  assign feed.csync    = pins[6];
  assign feed.t1_rst   = ctl.cclr_hi && ctl.cclr_lo && pins[6];
  assign feed.t1_clk   = (ctl.cks >= CKS_EXT_MIN) && pins[5];
  assign feed.frt_d    = pins[5];
  assign feed.hsync_in = pins[5];
  assign feed.frt_c    = pins[4];
endmodule

// >>> hw/pm6_top.sv
/*
  Port six: eight-pin general port with function selection for bits 7 to 4.
  Assumes pin inputs and timer outputs are synchronous to clk, and that
  hw_stby is a synchronous, active-high hardware standby indication.
*/
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pm6_top
  import pm6_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  hw_stby,
  input  wire logic [pm6_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [pm6_pkg::DW-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [pm6_pkg::AW-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [pm6_pkg::DW-1:0]     s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [7:0]            pin_i,
  output logic [7:0]                 pin_o,
  output logic [7:0]                 pin_oe,
  input  wire pm6_pkg::pm6_per_out_t per_i,
  output pm6_pkg::pm6_feed_t         feed_o
);
  logic [7:0]       dir_r;
  logic [7:0]       lat_r;
  logic [7:0]       ctl_r;
  logic [SEL_W-1:0] sel_r;
  logic [7:0]       dir_nxt;
  logic [7:0]       lat_nxt;
  logic [7:0]       ctl_nxt;
  logic [SEL_W-1:0] sel_nxt;
  logic [7:0]       pin_o_nxt;
  logic [7:0]       pin_oe_nxt;
  pm6_feed_t        feed_nxt;
  pm6_ctrl_t        ctl;
  logic             wr_en;
  logic [AW-1:0]    wr_addr;
  logic [DW-1:0]    wr_data;
  logic [3:0]       wr_strb;
  logic [AW-1:0]    rd_addr;
  logic [DW-1:0]    rd_data;
  logic [3:0]       whit;
  logic [3:0]       rhit;
  logic [7:0]       port_rd;
  logic             lo_we;
  logic             hi_we;
  logic             rst_b_dly_r;

  pm6_axil_slave u_bus (
    .clk     (clk),
    .rst_b   (rst_b),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // Register decode for both directions of access.
  assign whit  = reg_hit(wr_addr);
  assign rhit  = reg_hit(rd_addr);
  assign lo_we = wr_en && wr_strb[0];
  assign hi_we = wr_en && wr_strb[1];

  // Next register values; hardware standby wins over any write.
  assign dir_nxt = hw_stby ? DIR_RST : (lo_we && whit[0]) ? wr_data[7:0] : dir_r;
  assign lat_nxt = hw_stby ? LAT_RST : (lo_we && whit[1]) ? wr_data[7:0] : lat_r;
  assign ctl_nxt = hw_stby ? CTL_RST : (lo_we && whit[2]) ? wr_data[7:0] : ctl_r;
  assign sel_nxt = hw_stby ? SEL_RST :
                   {(hi_we && whit[3]) ? wr_data[SEL_W-1:8] : sel_r[SEL_W-1:8],
                    (lo_we && whit[3]) ? wr_data[7:0] : sel_r[7:0]};

  // Port read: latch for output bits, pin level for input bits.
  assign port_rd = (dir_r & lat_r) | (~dir_r & pin_i);

  // Read data; the direction register never shows what it stores.
  assign rd_data = rhit[0] ? {PAD24, DIR_RD_VAL} :
                   rhit[1] ? {PAD24, port_rd} :
                   rhit[2] ? {PAD24, ctl_r} :
                   rhit[3] ? {PAD20, sel_r} : '0;

  // Control fields handed to the function mux.
  assign ctl.hsync_out_enable     = ctl_r[CTL_HOE];
  assign ctl.clamp_out_enable    = ctl_r[CTL_CLAMP_OUT_ENABLE];
  assign ctl.frt_out_b_enable     = ctl_r[CTL_OEB];
  assign ctl.cclr_hi = ctl_r[CTL_CCLR_HI];
  assign ctl.cclr_lo = ctl_r[CTL_CCLR_LO];
  assign ctl.cks     = ctl_r[CTL_CKS_LSB +: CKS_W];
  assign ctl.osx     = sel_r[SEL_OSX_LSB +: OS_W];
  assign ctl.os1     = sel_r[SEL_OS1_LSB +: OS_W];
  assign ctl.os0     = sel_r[SEL_OS0_LSB +: OS_W];

  // Mode-independent function selection for all eight pins.
  pm6_pin_mux u_mux (
    .dir    (dir_r),
    .lat    (lat_r),
    .pins   (pin_i),
    .ctl    (ctl),
    .per    (per_i),
    .pin_o  (pin_o_nxt),
    .pin_oe (pin_oe_nxt),
    .feed   (feed_nxt)
  );

  // Registers; nothing here is touched by software standby.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      dir_r <= DIR_RST;
      lat_r <= LAT_RST;
      ctl_r <= CTL_RST;
      sel_r <= SEL_RST;
    end
    else
    begin
      dir_r <= dir_nxt;
      lat_r <= lat_nxt;
      ctl_r <= ctl_nxt;
      sel_r <= sel_nxt;
    end
  end

  // Pin drivers and feeds leave the block from flip-flops.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pin_o  <= 8'h00;
      pin_oe <= 8'h00;
      feed_o <= '0;
    end
    else
    begin
      pin_o  <= pin_o_nxt;
      pin_oe <= pin_oe_nxt;
      feed_o <= feed_nxt;
    end
  end

  // Reset copy one edge late; the reset edge itself must not start a check.
  always_ff @(posedge clk)
  begin
    rst_b_dly_r <= rst_b;
  end

  // Checks on the registers, the read path and the pin selection.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b || !rst_b_dly_r);

  sequence s_ar_dir;
    s_axi_arvalid && s_axi_arready && rhit[0];
  endsequence

  sequence s_ar_port;
    s_axi_arvalid && s_axi_arready && rhit[1];
  endsequence

  property p_rd_dir;
    s_ar_dir |=> s_axi_rvalid && s_axi_rdata[7:0] == DIR_RD_VAL;
  endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("direction read leaked");

  property p_rd_port;
    s_ar_port |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(port_rd);
  endproperty
  a_rd_port: assert property (p_rd_port) else $error("port read wrong");

  property p_rd_mix;
    s_ar_port |=> s_axi_rdata[7:0] == (($past(dir_r) & $past(lat_r)) |
                                       (~$past(dir_r) & $past(pin_i)));
  endproperty
  a_rd_mix: assert property (p_rd_mix) else $error("port read mix wrong");

  property p_stby;
    hw_stby |=> dir_r == DIR_RST && lat_r == LAT_RST;
  endproperty
  a_stby: assert property (p_stby) else $error("standby did not clear");

  property p_b5_io;
    1'b1 |=> pin_oe[5] == $past(dir_r[5]) && pin_o[5] == $past(lat_r[5]);
  endproperty
  a_b5_io: assert property (p_b5_io) else $error("bit five not plain port");

  property p_b7_sync;
    ctl.hsync_out_enable |=> pin_oe[7] && pin_o[7] == $past(per_i.hsync);
  endproperty
  a_b7_sync: assert property (p_b7_sync) else $error("bit seven sync lost");

  property p_b7_aux;
    !ctl.hsync_out_enable && |ctl.osx |=> pin_oe[7] && pin_o[7] == $past(per_i.aux_x);
  endproperty
  a_b7_aux: assert property (p_b7_aux) else $error("bit seven aux lost");

  property p_b7_port;
    !ctl.hsync_out_enable && !(|ctl.osx) && !(|ctl.os1) |=> pin_oe[7] == $past(dir_r[7]);
  endproperty
  a_b7_port: assert property (p_b7_port) else $error("bit seven port wrong");

  property p_b6_frt;
    ctl.frt_out_b_enable |=> pin_oe[6] && pin_o[6] == $past(per_i.frt_b);
  endproperty
  a_b6_frt: assert property (p_b6_frt) else $error("bit six timer lost");

  property p_b4_clamp;
    ctl.clamp_out_enable |=> pin_oe[4] && pin_o[4] == $past(per_i.clamp);
  endproperty
  a_b4_clamp: assert property (p_b4_clamp) else $error("bit four clamp lost");

  property p_owned_keep;
    ctl.frt_out_b_enable && !wr_en && !hw_stby |=> $stable(dir_r) && $stable(lat_r);
  endproperty
  a_owned_keep: assert property (p_owned_keep) else $error("port regs disturbed");

  property p_t1_rst;
    1'b1 |=> feed_o.t1_rst ==
             ($past(ctl.cclr_hi) && $past(ctl.cclr_lo) && $past(pin_i[6]));
  endproperty
  a_t1_rst: assert property (p_t1_rst) else $error("timer reset feed wrong");

  property p_t1_clk;
    ctl.cks >= CKS_EXT_MIN |=> feed_o.t1_clk == $past(pin_i[5]);
  endproperty
  a_t1_clk: assert property (p_t1_clk) else $error("timer clock feed wrong");

  property p_feeds;
    1'b1 |=> feed_o.exp_conv == $past(pin_i[7:4]) && feed_o.csync == $past(pin_i[6])
             && feed_o.frt_d == $past(pin_i[5]) && feed_o.hsync_in == $past(pin_i[5])
             && feed_o.frt_c == $past(pin_i[4]);
  endproperty
  a_feeds: assert property (p_feeds) else $error("input feed wrong");

  property p_b7_timer_unit_one;
    !ctl.hsync_out_enable && !(|ctl.osx) && |ctl.os1 |=> pin_oe[7] && pin_o[7] == $past(per_i.timer_unit_one);
  endproperty
  a_b7_timer_unit_one: assert property (p_b7_timer_unit_one) else $error("bit seven timer 1 lost");

  property p_b6_port;
    !ctl.frt_out_b_enable |=> pin_oe[6] == $past(dir_r[6]) && pin_o[6] == $past(lat_r[6]);
  endproperty
  a_b6_port: assert property (p_b6_port) else $error("bit six port wrong");

  property p_b4_timer_unit_zero;
    !ctl.clamp_out_enable && |ctl.os0 |=> pin_oe[4] && pin_o[4] == $past(per_i.timer_unit_zero);
  endproperty
  a_b4_timer_unit_zero: assert property (p_b4_timer_unit_zero) else $error("bit four timer 0 lost");

  property p_b4_port;
    !ctl.clamp_out_enable && !(|ctl.os0) |=> pin_oe[4] == $past(dir_r[4]) && pin_o[4] == $past(lat_r[4]);
  endproperty
  a_b4_port: assert property (p_b4_port) else $error("bit four port wrong");

  property p_lo_io;
    1'b1 |=> pin_oe[3:0] == $past(dir_r[3:0]) && pin_o[3:0] == $past(lat_r[3:0]);
  endproperty
  a_lo_io: assert property (p_lo_io) else $error("low bits not plain port");
endmodule

// >>> bench/pm6_far_side.sv
/*
  Far-side model of the port-six pins: board levels and timer outputs.
  Assumes the bench hands in a fresh random word at every clock.
*/
`timescale 1ns/1ps
module pm6_far_side
  import pm6_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             hold,
  input  wire logic [15:0]      rnd,
  input  wire logic [7:0]       pin_o,
  input  wire logic [7:0]       pin_oe,
  output logic [7:0]            pin_i,
  output pm6_pkg::pm6_per_out_t per_i
);
  logic [7:0] board_r;

  // Undriven pins and timer outputs change every cycle unless frozen.
  always_ff @(posedge clk)
  begin
    if (!hold)
    begin
      board_r <= rnd[7:0];
      per_i   <= rnd[13:8];
    end
  end

  // A pin that the block drives reads back its own drive level.
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & board_r);
endmodule

// >>> bench/port6_upper_pin_mux_tb.sv
/*
  Self-checking bench for the port-six block against a register model.
  Assumes the far-side model resolves every pin level.
*/
`timescale 1ns/1ps
module port6_upper_pin_mux_tb;
  import pm6_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, hw_stby = 1'b0, hold = 1'b0;
  logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DW-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] pin_i, pin_o, pin_oe;
  logic [15:0] rnd = 16'h0000;
  pm6_per_out_t per_i;
  pm6_feed_t feed_o;
  logic [31:0] seed = 32'hB18C;
  int miscompares = 0, tests_run = 0;
  int dir_m = 0, lat_m = 0, ctl_m = 0, sel_m = 0;

  pm6_top dut (.clk(clk), .rst_b(rst_b), .hw_stby(hw_stby), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .per_i(per_i), .feed_o(feed_o));

  pm6_far_side far (.clk(clk), .hold(hold), .rnd(rnd), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_i(pin_i), .per_i(per_i));

  // Clock at 250 MHz.
  initial
    forever #2 clk = ~clk;

  // Random stream for the far side.
  always @(posedge clk)
    rnd <= 16'(xs());

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic axw(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] st,
                     output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [1:0] r;
    axw(idx, d, 4'hF, r);
    chk("bresp", 32'(r), 32'(RESP_OK));
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axr(idx, d, r);
    chk("rdata", d, exp);
    chk("rresp", 32'(r), 32'(er));
  endtask

  // Expected drive and feeds from the model registers and the sampled pins.
  function automatic void exp_pins(input logic [7:0] pi, input pm6_per_out_t pp,
                                   output logic [7:0] eo, output logic [7:0] eoe,
                                   output pm6_feed_t ef);
    logic [7:0] d, l, c;
    logic [11:0] s;
    d = 8'(dir_m);
    l = 8'(lat_m);
    c = 8'(ctl_m);
    s = 12'(sel_m);
    eoe = d;
    eo = l;
    eo[7] = c[0] ? pp.hsync : (s[3:0] != 4'h0) ? pp.aux_x : (s[7:4] != 4'h0) ? pp.timer_unit_one : l[7];
    eoe[7] = c[0] | (s[7:0] != 8'h00) | d[7];
    eo[6] = c[2] ? pp.frt_b : l[6];
    eoe[6] = c[2] | d[6];
    eo[4] = c[1] ? pp.clamp : (s[11:8] != 4'h0) ? pp.timer_unit_zero : l[4];
    eoe[4] = c[1] | (s[11:8] != 4'h0) | d[4];
    ef = {pi[7:4], pi[6], c[4] & c[3] & pi[6], (c[7:5] >= CKS_EXT_MIN) & pi[5],
          pi[5], pi[5], pi[4]};
  endfunction

  // Compares the registered pin outputs with the inputs of the cycle before.
  task automatic pins(input int n);
    logic [7:0] pi, eo, eoe;
    pm6_per_out_t pp;
    pm6_feed_t ef;
    @(negedge clk);
    pi = pin_i;
    pp = per_i;
    repeat (n)
    begin
      exp_pins(pi, pp, eo, eoe, ef);
      @(negedge clk);
      chk("pin_oe", 32'(pin_oe), 32'(eoe));
      chk("pin_o", 32'(pin_o & eoe), 32'(eo & eoe));
      chk("feed_o", 32'(feed_o), 32'(ef));
      pi = pin_i;
      pp = per_i;
    end
  endtask

  // Watchdog against a hung handshake.
  initial
  begin
    #200000;
    miscompares++;
    finish_test();
  end

  // Main sequence.
  initial
  begin
    logic [31:0] r1, r2, d;
    logic [1:0] rs;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    pins(2);
    rdchk(IDX_DIR, 32'(DIR_RD_VAL), RESP_OK);
    for (int i = 0; i < 40; i++)
    begin
      r1 = xs();
      r2 = xs();
      dir_m = int'(r1[7:0]);
      lat_m = int'(r1[15:8]);
      ctl_m = int'(r1[23:16]);
      sel_m = int'(r2[11:0] & {{4{r2[12]}}, {4{r2[13]}}, {4{r2[14]}}});
      wr(IDX_DIR, 32'(dir_m));
      wr(IDX_LAT, 32'(lat_m));
      wr(IDX_CTL, 32'(ctl_m));
      wr(IDX_SEL, 32'(sel_m));
      hold <= 1'b0;
      pins(6);
      hold <= 1'b1;
      @(posedge clk);
      axr(IDX_LAT, d, rs);
      chk("port_read", d, 32'((8'(dir_m) & 8'(lat_m)) | (~8'(dir_m) & pin_i)));
      rdchk(IDX_DIR, 32'(DIR_RD_VAL), RESP_OK);
      rdchk(IDX_CTL, 32'(ctl_m), RESP_OK);
      rdchk(IDX_SEL, 32'(sel_m), RESP_OK);
    end
    // Low byte strobe off leaves the latch alone; unmapped word is refused.
    wr(IDX_DIR, 32'h000000FF);
    axw(IDX_LAT, 32'h000000FF, 4'hE, rs);
    rdchk(IDX_LAT, 32'(lat_m), RESP_OK);
    axw(16'hFFBA, 32'h000000FF, 4'hF, rs);
    chk("bresp", 32'(rs), 32'(RESP_ERR));
    rdchk(16'hFFBA, 32'h00000000, RESP_ERR);
    // Hardware standby, then a second reset, both clear every register.
    for (int k = 0; k < 2; k++)
    begin
      wr(IDX_DIR, 32'h000000FF);
      wr(IDX_LAT, 32'h000000A5);
      wr(IDX_CTL, 32'h000000FF);
      wr(IDX_SEL, 32'h00000FFF);
      @(posedge clk);
      if (k == 0)
        hw_stby <= 1'b1;
      else
        rst_b <= 1'b0;
      @(posedge clk);
      hw_stby <= 1'b0;
      rst_b <= 1'b1;
      @(posedge clk);
      dir_m = 0;
      lat_m = 0;
      ctl_m = 0;
      sel_m = 0;
      pins(3);
      rdchk(IDX_CTL, 32'h00000000, RESP_OK);
      wr(IDX_DIR, 32'h000000FF);
      rdchk(IDX_LAT, 32'h00000000, RESP_OK);
    end
    finish_test();
  end
endmodule
